// ==== hdl/drrc_top.sv ====
// row window, row duty and ramp configuration bank with its row sequencing
// assumes frame_start, line_start, stereo_mode, frame_enabled, gamma_sample come from mclk-domain video logic
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "drrc_params.svh"

// What this block does
// - duty field zero disables duty; otherwise rows lit twice the field in line periods
// - in stereo mode, duty control acts only on the frame not enabled for display
// - force-high bit set drives every ramp dac output to maximum; clear runs normally
// - flyback bit one selects 500 ns; zero selects the longer flyback time
// - two-bit ramp delay: 00 half clock early, 01 none, 10 half clock late
// - bias code 000 turns bias off; 001 to 111 raise current in equal steps
// - pump hold bit set suspends electrode pumping during gamma sampling; clear pumps normally
module drrc_top
   import drrc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [1:0]       avs_response,
   input  wire logic        frame_start,
   input  wire logic        line_start,
   input  wire logic        stereo_mode,
   input  wire logic        frame_enabled,
   input  wire logic        gamma_sample,
   output logic [10:0]      row_index,
   output logic             row_display,
   output logic             row_reset_strobe,
   output logic [10:0]      row_reset_index,
   output logic [7:0]       ramp_dac_code,
   output logic             ramp_flyback,
   output logic             ramp_run,
   output logic             ramp_dac_force_high,
   output logic             ramp_buffer_monitor_enable,
   output logic [1:0]       ramp_delay_select,
   output logic [3:0]       ramp_buffer_current_code,
   output logic [3:0]       ramp_amp_current_code,
   output logic             external_reference_enable,
   output logic [2:0]       bias_current_level,
   output logic             bias_current_on,
   output logic             common_electrode_pump_hold
);

   logic [7:0]     row_window_top;
   logic [7:0]     row_window_bottom;
   logic [7:0]     row_duty_control;
   logic [7:0]     ramp_control;
   logic [7:0]     ramp_current_control;
   logic [7:0]     ramp_dac_max_value;
   logic [7:0]     bias_current_control;
   logic [10:0]    row_count;
   logic [10:0]    cur_row;
   logic [10:0]    duty_span;
   logic [10:0]    next_reset_index;
   logic           duty_apply;
   logic [3:0]     bus_index;
   logic           bus_request;
   logic           write_fire;
   logic [31:0]    read_value;
   drrc_ramp_cfg_s ramp_cfg;
   drrc_ramp_out_s ramp_out;

   function automatic logic is_mapped(input logic [3:0] idx);
      is_mapped = (idx >= `DRRC_IDX_TOP) && (idx <= `DRRC_IDX_STATUS);
   endfunction

   function automatic logic in_window(input logic [10:0] row,
                                      input logic [7:0]  top,
                                      input logic [7:0]  bottom);
      in_window = (row >= {3'h0, top}) && (row <= `DRRC_ROWS - 11'd1 - {3'h0, bottom});
   endfunction

   function automatic logic wr_hit(input logic       fire,
                                   input logic [3:0] sel,
                                   input logic [3:0] idx);
      wr_hit = fire && (sel == idx);
   endfunction

   assign bus_index   = avs_address[5:2];
   assign bus_request = avs_read || avs_write;
   // write lands only on the edge where the master sees waitrequest low
   assign write_fire  = avs_write && !avs_waitrequest && avs_byteenable[0];

   // one wait state per access, then waitrequest drops for one cycle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !(bus_request && avs_waitrequest);
   end

   always_comb
   begin
      read_value = 32'h0000_0000;
      unique case (bus_index)
         `DRRC_IDX_TOP     : read_value[7:0] = row_window_top;
         `DRRC_IDX_BOTTOM  : read_value[7:0] = row_window_bottom;
         `DRRC_IDX_DUTY    : read_value[7:0] = row_duty_control;
         `DRRC_IDX_RAMP    : read_value[7:0] = ramp_control;
         `DRRC_IDX_CURRENT : read_value[7:0] = ramp_current_control;
         `DRRC_IDX_DACMAX  : read_value[7:0] = ramp_dac_max_value;
         `DRRC_IDX_BIAS    : read_value[7:0] = bias_current_control;
         `DRRC_IDX_STATUS  : read_value[13:0] = {row_display, ramp_run, duty_apply, row_index};
         default           : read_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (bus_request && avs_waitrequest)
         avs_readdata <= avs_read ? read_value : 32'h0000_0000;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_response <= `DRRC_RESP_OKAY;
      else if (bus_request && avs_waitrequest)
         avs_response <= is_mapped(bus_index) ? `DRRC_RESP_OKAY : `DRRC_RESP_DECODE;
   end

   // the config registers, written from byte lane 0
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         row_window_top <= `DRRC_RST_TOP;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_TOP))
         row_window_top <= avs_writedata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         row_window_bottom <= `DRRC_RST_BOTTOM;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_BOTTOM))
         row_window_bottom <= avs_writedata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         row_duty_control <= `DRRC_RST_DUTY;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_DUTY))
         row_duty_control <= avs_writedata[7:0];
   end

   // reserved bits of ramp control are kept at zero
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_control <= `DRRC_RST_RAMP;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_RAMP))
         ramp_control <= avs_writedata[7:0] & 8'h2f;
   end

   // current codes stored as written; 0000 is the host's to avoid
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_current_control <= `DRRC_RST_CURRENT;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_CURRENT))
         ramp_current_control <= avs_writedata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_dac_max_value <= `DRRC_RST_DACMAX;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_DACMAX))
         ramp_dac_max_value <= avs_writedata[7:0];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         bias_current_control <= `DRRC_RST_BIAS;
      else if (wr_hit(write_fire, bus_index, `DRRC_IDX_BIAS))
         bias_current_control <= avs_writedata[7:0] & 8'h1f;
   end

   // row sequencing: frame_start also marks row zero's line
   assign cur_row   = frame_start ? 11'd0 : row_count;
   assign duty_span = {2'b00, row_duty_control, 1'b0};
   assign next_reset_index = (cur_row >= duty_span) ? cur_row - duty_span
                                                    : cur_row + `DRRC_ROWS - duty_span;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         duty_apply <= 1'b1;
      else if (frame_start)
         duty_apply <= !stereo_mode || !frame_enabled;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         row_count <= 11'd0;
      else if (line_start || frame_start)
      begin
         // stops at the last row if extra lines arrive before a new frame
         if (cur_row != `DRRC_ROWS - 11'd1)
            row_count <= cur_row + 11'd1;
         else
            row_count <= cur_row;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_index   <= 11'd0;
         row_display <= 1'b0;
      end
      else if (line_start || frame_start)
      begin
         row_index   <= cur_row;
         row_display <= in_window(cur_row, row_window_top, row_window_bottom);
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         row_reset_strobe <= 1'b0;
         row_reset_index  <= 11'd0;
      end
      else
      begin
         // a row lit since duty_span lines ago is turned off now
         row_reset_strobe <= (line_start || frame_start) && (row_duty_control != 8'h00) && duty_apply;
         if (line_start || frame_start)
            row_reset_index <= next_reset_index;
      end
   end

   // analog control levels, registered from the config bank; pump hold is also gated by gamma_sample
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_dac_force_high <= 1'b0;
      else
         ramp_dac_force_high <= ramp_control[`DRRC_RAMP_HIGH_BIT];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_buffer_monitor_enable <= 1'b0;
      else
         ramp_buffer_monitor_enable <= ramp_control[`DRRC_RAMP_MON_BIT];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_delay_select <= `DRRC_DLY_NONE;
      else
         ramp_delay_select <= ramp_control[`DRRC_RAMP_DLY_HI:`DRRC_RAMP_DLY_LO];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_buffer_current_code <= 4'h4;
      else
         ramp_buffer_current_code <= ramp_current_control[`DRRC_CUR_BUF_HI:`DRRC_CUR_BUF_LO];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_amp_current_code <= 4'h4;
      else
         ramp_amp_current_code <= ramp_current_control[`DRRC_CUR_AMP_HI:`DRRC_CUR_AMP_LO];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         external_reference_enable <= 1'b0;
      else
         external_reference_enable <= bias_current_control[`DRRC_BIAS_EXT_BIT];
   end

   // level code steps the bias in equal increments; zero is off
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         bias_current_level <= 3'h1;
      else
         bias_current_level <= bias_current_control[`DRRC_BIAS_CODE_HI:`DRRC_BIAS_CODE_LO];
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         bias_current_on <= 1'b1;
      else
         bias_current_on <= bias_current_control[`DRRC_BIAS_CODE_HI:`DRRC_BIAS_CODE_LO] != 3'h0;
   end

   // hold lags gamma_sample by one cycle
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         common_electrode_pump_hold <= 1'b0;
      else
         common_electrode_pump_hold <= bias_current_control[`DRRC_BIAS_PUMP_BIT] && gamma_sample;
   end

   assign ramp_cfg.monitor_en    = ramp_control[`DRRC_RAMP_MON_BIT];
   assign ramp_cfg.force_high    = ramp_control[`DRRC_RAMP_HIGH_BIT];
   assign ramp_cfg.flyback_short = ramp_control[`DRRC_RAMP_FLY_BIT];
   assign ramp_cfg.delay_sel     = ramp_control[`DRRC_RAMP_DLY_HI:`DRRC_RAMP_DLY_LO];

   drrc_ramp_timer u_ramp_timer
   (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .line_start (line_start || frame_start),
      .cfg        (ramp_cfg),
      .dac_max    (ramp_dac_max_value),
      .ramp       (ramp_out)
   );

   assign ramp_dac_code = ramp_out.dac_code;
   assign ramp_flyback  = ramp_out.flyback;
   assign ramp_run      = ramp_out.run;

endmodule

// ==== hdl/drrc_params.svh ====
// offsets, field positions, reset values and timing counts of the row and ramp control bank
// assumes inclusion by drrc_top.sv and the ramp timer, not by drrc_pkg.sv; guarded against double inclusion
`ifndef DRRC_PARAMS_SVH
`define DRRC_PARAMS_SVH

// register indices; byte address is four times the index
`define DRRC_IDX_TOP        4'h5
`define DRRC_IDX_BOTTOM     4'h6
`define DRRC_IDX_DUTY       4'h7
`define DRRC_IDX_RAMP       4'h8
`define DRRC_IDX_CURRENT    4'h9
`define DRRC_IDX_DACMAX     4'ha
`define DRRC_IDX_BIAS       4'hb
`define DRRC_IDX_STATUS     4'hc

// reset values
`define DRRC_RST_TOP        8'h06
`define DRRC_RST_BOTTOM     8'h06
`define DRRC_RST_DUTY       8'h00
`define DRRC_RST_RAMP       8'h01
`define DRRC_RST_CURRENT    8'h44
`define DRRC_RST_DACMAX     8'h80
`define DRRC_RST_BIAS       8'h01

// field positions
`define DRRC_RAMP_MON_BIT   5
`define DRRC_RAMP_HIGH_BIT  3
`define DRRC_RAMP_FLY_BIT   2
`define DRRC_RAMP_DLY_HI    1
`define DRRC_RAMP_DLY_LO    0
`define DRRC_CUR_BUF_HI     7
`define DRRC_CUR_BUF_LO     4
`define DRRC_CUR_AMP_HI     3
`define DRRC_CUR_AMP_LO     0
`define DRRC_BIAS_PUMP_BIT  4
`define DRRC_BIAS_EXT_BIT   3
`define DRRC_BIAS_CODE_HI   2
`define DRRC_BIAS_CODE_LO   0

// ramp delay codes
`define DRRC_DLY_ADVANCE    2'b00
`define DRRC_DLY_NONE       2'b01
`define DRRC_DLY_LATE       2'b10

// panel geometry
`define DRRC_ROWS           11'd1024

// timing
`define DRRC_CLK_NS         4
`define DRRC_FLY_SHORT_NS   500
`define DRRC_FLY_LONG_NS    800
`define DRRC_FLY_SHORT_CYC  ((`DRRC_FLY_SHORT_NS + `DRRC_CLK_NS - 1) / `DRRC_CLK_NS)
`define DRRC_FLY_LONG_CYC   ((`DRRC_FLY_LONG_NS + `DRRC_CLK_NS - 1) / `DRRC_CLK_NS)

// bus answers
`define DRRC_RESP_OKAY      2'b00
`define DRRC_RESP_DECODE    2'b11

`endif

// ==== hdl/drrc_pkg.sv ====
// types shared by the row and ramp control bank and its ramp timer
// assumes drrc_params.svh is reachable on the include path
package drrc_pkg;

   typedef struct packed
   {
      logic       monitor_en;
      logic       force_high;
      logic       flyback_short;
      logic [1:0] delay_sel;
   } drrc_ramp_cfg_s;

   typedef struct packed
   {
      logic       flyback;
      logic       run;
      logic [7:0] dac_code;
   } drrc_ramp_out_s;

   typedef enum logic [1:0]
   {
      DRRC_IDLE    = 2'b00,
      DRRC_DELAY   = 2'b01,
      DRRC_FLYBACK = 2'b11,
      DRRC_RUN     = 2'b10
   } drrc_ramp_state_e;

endpackage

// ==== hdl/drrc_ramp_timer.sv ====
// ramp timer: per-line delay, flyback window and rising dac code
// assumes line_start is a one-cycle pulse on mclk; one mclk is half a pixel clock
`timescale 1ns/1ns
`include "drrc_params.svh"

module drrc_ramp_timer
   import drrc_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           rst_n,
   input  wire logic           line_start,
   input  wire drrc_ramp_cfg_s cfg,
   input  wire logic [7:0]     dac_max,
   output drrc_ramp_out_s      ramp
);

   drrc_ramp_state_e state;
   logic [7:0]       count;
   logic [7:0]       ramp_code;
   logic [1:0]       wait_cycles;
   logic [7:0]       fly_cycles;

   always_comb
   begin
      unique case (cfg.delay_sel)
         `DRRC_DLY_ADVANCE : wait_cycles = 2'd0;
         `DRRC_DLY_LATE    : wait_cycles = 2'd2;
         default           : wait_cycles = 2'd1;
      endcase
   end

   assign fly_cycles = cfg.flyback_short ? 8'(`DRRC_FLY_SHORT_CYC - 1) : 8'(`DRRC_FLY_LONG_CYC - 1);

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= DRRC_IDLE;
         count     <= 8'h00;
         ramp_code <= 8'h00;
      end
      else if (line_start)
      begin
         ramp_code <= 8'h00;
         if (wait_cycles == 2'd0)
         begin
            state <= DRRC_FLYBACK;
            count <= fly_cycles;
         end
         else
         begin
            state <= DRRC_DELAY;
            count <= {6'h00, wait_cycles - 2'd1};
         end
      end
      else
      begin
         unique case (state)
            DRRC_IDLE    : count <= 8'h00;
            DRRC_DELAY   :
            begin
               count <= (count == 8'h00) ? fly_cycles : count - 8'h01;
               if (count == 8'h00)
                  state <= DRRC_FLYBACK;
            end
            DRRC_FLYBACK :
            begin
               count <= count - 8'h01;
               if (count == 8'h00)
                  state <= DRRC_RUN;
            end
            DRRC_RUN     :
            begin
               if (ramp_code < dac_max)
                  ramp_code <= ramp_code + 8'h01;
            end
         endcase
      end
   end

   // outputs registered so the dac sees no decode glitches
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp <= '0;
      else
      begin
         ramp.flyback  <= (state == DRRC_FLYBACK);
         ramp.run      <= (state == DRRC_RUN);
         ramp.dac_code <= cfg.force_high ? 8'hff : ramp_code;
      end
   end

endmodule

// ==== dv/drrc_chk.sv ====
// port assertions for the row and ramp control bank
// assumes a bind onto drrc_top; one mclk domain, async rst_n
`timescale 1ns/1ns
module drrc_chk
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       frame_start,
   input wire logic       line_start,
   input wire logic       gamma_sample,
   input wire logic       row_reset_strobe,
   input wire logic [7:0] ramp_dac_code,
   input wire logic       ramp_flyback,
   input wire logic       ramp_run,
   input wire logic       ramp_dac_force_high,
   input wire logic [2:0] bias_current_level,
   input wire logic       bias_current_on,
   input wire logic       common_electrode_pump_hold
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // a line start inside flyback would cut the count short
   logic [8:0] fly_cnt;
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
         fly_cnt <= 9'h0;
      else
         fly_cnt <= ramp_flyback ? fly_cnt + 9'h1 : 9'h0;
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
   sequence s_fly_end; $fell(ramp_flyback) && !$past(line_start); endsequence
   wait_state_a: assert property (s_req |=> s_ack)
      else $error("bus answer late");
   strobe_cause_a: assert property (row_reset_strobe |-> $past(line_start || frame_start))
      else $error("strobe without line");
   fly_start_a: assert property (line_start |-> ##[2:4] ramp_flyback)
      else $error("flyback start late");
   fly_len_a: assert property (s_fly_end |-> fly_cnt == 9'd125 || fly_cnt == 9'd200)
      else $error("flyback length");
   run_after_a: assert property (s_fly_end |-> ramp_run)
      else $error("no run after flyback");
   force_high_a: assert property (ramp_dac_force_high [*3] |-> ramp_dac_code == 8'hff)
      else $error("dac not at max");
   bias_on_a: assert property (bias_current_on == (bias_current_level != 3'h0))
      else $error("bias on mismatch");
   pump_hold_a: assert property (common_electrode_pump_hold |-> $past(gamma_sample))
      else $error("hold outside sampling");
endmodule
bind drrc_top drrc_chk i_drrc_chk (.mclk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .frame_start,
   .line_start, .gamma_sample, .row_reset_strobe, .ramp_dac_code, .ramp_flyback, .ramp_run,
   .ramp_dac_force_high, .bias_current_level, .bias_current_on, .common_electrode_pump_hold);

// ==== dv/drrc_host_model.sv ====
// host controller model: Avalon-MM master for single register cycles
// assumes the bench calls xfer; the slave answers through waitrequest
`timescale 1ns/1ns
module drrc_host_model
(
   input  wire logic        mclk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   input  wire logic [1:0]  avs_response,
   output logic             avs_read,
   output logic             avs_write,
   output logic [5:0]       avs_address,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable
);
   initial
   begin
      {avs_read, avs_write} = 2'b00;
      {avs_address, avs_writedata, avs_byteenable} = '0;
   end
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] rd, output logic [1:0] rsp);
      @(posedge mclk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      // values read here are those that stood before the edge; only the bench watchdog ends a hang
      do
         @(posedge mclk);
      while (avs_waitrequest);
      rd = avs_readdata;
      rsp = avs_response;
      {avs_read, avs_write} <= 2'b00;
      // released address and write data inverted so stale values cannot pass
      avs_address <= ~avs_address;
      avs_writedata <= ~avs_writedata;
   endtask
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the row and ramp control bank
// assumes drrc_top, its bound checker and the host model compile first
`timescale 1ns/1ns
`include "drrc_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        frame_start = 1'b0, line_start = 1'b0, stereo_mode = 1'b0, frame_enabled = 1'b0;
   logic        gamma_sample = 1'b0, avs_read, avs_write, avs_waitrequest, row_display, row_reset_strobe;
   logic        ramp_flyback, ramp_run, ramp_dac_force_high, ramp_buffer_monitor_enable;
   logic        external_reference_enable, bias_current_on, common_electrode_pump_hold, g;
   logic [1:0]  avs_response, ramp_delay_select, rsp;
   logic [2:0]  bias_current_level;
   logic [3:0]  avs_byteenable, ramp_buffer_current_code, ramp_amp_current_code, ri;
   logic [5:0]  avs_address;
   logic [7:0]  ramp_dac_code, rv;
   logic [7:0]  exp_reg [5:11];
   logic [10:0] row_index, row_reset_index;
   logic [31:0] avs_writedata, avs_readdata, rd;
   int          error_cnt = 0;
   int          check_count = 0;

   drrc_top i_drrc_top (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .avs_response, .frame_start, .line_start, .stereo_mode, .frame_enabled,
      .gamma_sample, .row_index, .row_display, .row_reset_strobe, .row_reset_index, .ramp_dac_code,
      .ramp_flyback, .ramp_run, .ramp_dac_force_high, .ramp_buffer_monitor_enable, .ramp_delay_select,
      .ramp_buffer_current_code, .ramp_amp_current_code, .external_reference_enable, .bias_current_level,
      .bias_current_on, .common_electrode_pump_hold);
   drrc_host_model i_drrc_host_model (.mclk, .avs_waitrequest, .avs_readdata, .avs_response, .avs_read,
      .avs_write, .avs_address, .avs_writedata, .avs_byteenable);

   always #2 mclk = ~mclk;
   always @(posedge mclk) gamma_sample <= 1'($urandom);

   function automatic logic [7:0] mask(input logic [3:0] i);
      return (i == 4'h8) ? 8'h2f : (i == 4'hb) ? 8'h1f : 8'hff;
   endfunction
   function automatic int dly(input logic [1:0] c);
      return (c == 2'b00) ? 1 : (c == 2'b10) ? 3 : 2;
   endfunction
   task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [3:0] be);
      i_drrc_host_model.xfer(1'b1, i, d, be, rd, rsp);
      `CHK(rsp, (i >= 4'h5 && i <= 4'hc) ? 2'b00 : 2'b11)
      if (be[0] && i >= 4'h5 && i <= 4'hb) exp_reg[i] = d & mask(i);
   endtask
   task automatic rdchk(input logic [3:0] i);
      i_drrc_host_model.xfer(1'b0, i, 8'h0, 4'hf, rd, rsp);
      `CHK(rsp, (i >= 4'h5 && i <= 4'hb) ? 2'b00 : 2'b11)
      `CHK(rd, (i >= 4'h5 && i <= 4'hb) ? {24'h0, exp_reg[i]} : 32'h0)
   endtask
   task automatic fields;
      repeat (2) @(posedge mclk);
      #1;
      `CHK(ramp_dac_force_high, exp_reg[8][3])
      `CHK(ramp_buffer_monitor_enable, exp_reg[8][5])
      `CHK(ramp_delay_select, exp_reg[8][1:0])
      `CHK({ramp_buffer_current_code, ramp_amp_current_code}, exp_reg[9])
      `CHK(external_reference_enable, exp_reg[11][3])
      `CHK(bias_current_level, exp_reg[11][2:0])
      `CHK(bias_current_on, exp_reg[11][2:0] != 3'h0)
      repeat (4)
      begin
         g = gamma_sample & exp_reg[11][4];
         @(posedge mclk);
         #1;
         `CHK(common_electrode_pump_hold, g)
      end
   endtask
   task automatic pulse(input logic f);
      @(posedge mclk);
      frame_start <= f;
      line_start <= !f;
      @(posedge mclk);
      frame_start <= 1'b0;
      line_start <= 1'b0;
      #1;
   endtask
   task automatic ramp(input logic [7:0] c);
      int n;
      wr(4'h8, c, 4'hf);
      pulse(1'b0);
      n = 0;
      while (!ramp_flyback && n < 10)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n, dly(c[1:0]))
      n = 0;
      while (ramp_flyback && n < 300)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHK(n, c[2] ? 125 : 200)
      repeat (260) @(posedge mclk);
      #1;
      `CHK(ramp_dac_code, c[3] ? 8'hff : exp_reg[10])
   endtask
   // row 0 strobe skipped: the duty gate is resampled on that very edge
   task automatic frame(input logic st, input logic en, input logic [7:0] duty);
      logic ap;
      @(posedge mclk);
      stereo_mode <= st;
      frame_enabled <= en;
      wr(4'h7, duty, 4'hf);
      ap = (duty != 8'h0) && !(st && en);
      for (int r = 0; r < 6; r++)
      begin
         pulse(r == 0);
         `CHK(row_index, 11'(r))
         `CHK(row_display, r >= 3)
         if (r > 0) `CHK(row_reset_strobe, ap)
         if (ap && r > 0) `CHK(row_reset_index, 11'((r + 1024 - 2 * duty) % 1024))
         repeat (215) @(posedge mclk);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #100000;
      error_cnt++;
      final_report;
   end
   initial
   begin
      void'($urandom(32'hcc21));
      exp_reg = '{8'h06, 8'h06, 8'h00, `DRRC_RST_RAMP, `DRRC_RST_CURRENT, `DRRC_RST_DACMAX, `DRRC_RST_BIAS};
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 14; i++) if (i != 12) rdchk(4'(i));
      i_drrc_host_model.xfer(1'b0, 4'hc, 8'h0, 4'hf, rd, rsp);
      `CHK(rd, 32'h800)
      fields;
      wr(4'hc, 8'hff, 4'hf);
      wr(4'hd, 8'h12, 4'hf);
      wr(4'h5, 8'h55, 4'he);
      rdchk(4'h5);
      repeat (20)
      begin
         ri = 4'(5 + $urandom % 7);
         rv = 8'($urandom);
         if (ri == 4'h9 && rv[7:4] == 4'h0) rv[7:4] = 4'h4;
         if (ri == 4'h9 && rv[3:0] == 4'h0) rv[3:0] = 4'h4;
         wr(ri, rv, ($urandom % 4 == 0) ? 4'he : 4'hf);
         rdchk(ri);
      end
      fields;
      wr(4'hb, 8'h00, 4'hf);
      fields;
      wr(4'hb, 8'h1f, 4'hf);
      fields;
      wr(4'ha, 8'(8'h10 + $urandom % 240), 4'hf);
      ramp(8'h00);
      ramp(8'h05);
      ramp(8'h02);
      ramp(8'h0f);
      wr(4'h5, 8'h03, 4'hf);
      wr(4'h6, 8'h00, 4'hf);
      frame(1'b0, 1'b0, 8'h01);
      frame(1'b1, 1'b1, 8'h02);
      frame(1'b1, 1'b0, 8'h03);
      frame(1'b0, 1'b1, 8'h00);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      exp_reg = '{8'h06, 8'h06, 8'h00, `DRRC_RST_RAMP, `DRRC_RST_CURRENT, `DRRC_RST_DACMAX, `DRRC_RST_BIAS};
      rdchk(4'h5);
      fields;
      `CHK({row_display, row_reset_strobe, row_index}, 13'h0)
      final_report;
   end
endmodule
